// File: rtl/host_monitor_control_port.sv
/*
  Host monitor and control port: parallel strobe interface in two bus styles
  plus a serial two-wire slave with auto-incrementing word pointer.
  Assumes host pins are asynchronous to mclk, the serial clock is a free
  clock port from the master, and open-drain wires are resolved outside.
*/
// Behaviour
// - Three host modes, two parallel, one serial
// - Serial mode when style high, both strobes low
// - Serial slave address from data bus bits
// - Select pins form paired address bits, bit6 zero
// - Chip select low qualifies other controls
// - First style read drives data bus
// - Write stores byte at selected register
// - Style low: read level plus data strobe
// - Tristate acknowledge on accepted parallel transfer
// - Serial side acts only as slave
// - Bypass outputs disabled unless bypass bit set
// - Write: address, word address, data, each acknowledged
// - Acknowledge matching address, ignore others
// - Pointer increments after each written byte
// - Read: word address, repeated start, transmit byte
// - Master ack continues read with next byte
`timescale 1ns/10ps
module host_monitor_control_port #(
  parameter bit ADDR_FROM_SELECTS = 1'b1    // 1: select pins, 0: data bus bits
) (
  input wire logic mclk,
  input wire logic rst,
  input wire logic sclLink,
  input wire logic serialDataIn,
  input wire host_port_pkg::byte_t hostDataIn,
  input wire host_port_pkg::regSel_t hostRegisterSelect,
  input wire logic chipSelectN,
  input wire logic readStrobeN,
  input wire logic writeStrobeN,
  input wire logic busStyleSelect,
  input wire logic slaveAddrSelect0,
  input wire logic slaveAddrSelect1,
  input wire logic slaveAddrSelect2,
  input wire host_port_pkg::byte_t [host_port_pkg::REG_COUNT-1:0] statusBytes,
  output logic [host_port_pkg::DATA_W-1:0] hostDataOut,
  output logic hostDataOeN,
  output logic transferAcknowledge,
  output logic transferAcknowledgeOeN,
  output logic serialDataOut,
  output logic serialDataOeN,
  output logic bypassSerialClockOut,
  output logic bypassSerialDataOut,
  output logic bypassOeN,
  output host_port_pkg::byte_t [host_port_pkg::REG_COUNT-1:0] controlBytes
);
  import host_port_pkg::*;

  // System clock side
  hostPins_t pinsNow;                       // Raw pins gathered
  hostPins_t pinsMeta;                      // First synchroniser stage
  hostPins_t pinsSync;                      // Usable pin values
  logic sclMeta, sclSync;                   // Serial clock level for bypass
  logic sdaMeta, sdaSync;                   // Serial data level for bypass
  logic i2cMode;                            // Serial mode strap decoded
  logic rdAct, wrAct;                       // Parallel access in progress
  logic wrPrev;                             // Write access seen last cycle
  logic wrEdge;                             // Write access just began
  logic [SLAVE_W-1:0] slaveAddrReg;         // Own serial address
  logic reqMeta, reqSync, reqSeen;          // Request toggle crossing
  logic reqNew;                             // Serial request pending
  byte_t rdDataReg;                         // Byte fetched for the serial side
  logic ackTog;                             // Answer toggle back to serial side

  // Serial clock side
  logic startTog;                           // Flips on each start condition
  logic startAck;                           // Last start consumed by the engine
  logic startPend;
  i2cState_t state;
  logic [3:0] bitCnt;                       // Bit within byte, 8 is the ack slot
  byte_t shiftIn;                           // Received byte
  byte_t txByte;                            // Byte being transmitted
  byte_t ptr;                               // Word address pointer
  regReq_t reqReg;                          // Request held stable for the crossing
  logic reqTog;
  logic ackMeta, ackSync, ackSeen;          // Answer toggle crossing
  byte_t rxData;                            // Prefetched byte for transmit
  logic [SLAVE_W-1:0] addrMeta, addrSync;   // Own address brought over
  logic addrMatch;

  // Fold the asynchronous pins into one bundle for synchronising
  always_comb begin
    pinsNow.chipSelectN = chipSelectN;
    pinsNow.readStrobeN = readStrobeN;
    pinsNow.writeStrobeN = writeStrobeN;
    pinsNow.busStyleSelect = busStyleSelect;
    pinsNow.addrSelect = {slaveAddrSelect2, slaveAddrSelect1, slaveAddrSelect0};
    pinsNow.sel = hostRegisterSelect;
    pinsNow.data = hostDataIn;
  end

  // Two-stage synchronisers for every pin that mclk logic reads
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      pinsMeta <= PINS_IDLE;
      pinsSync <= PINS_IDLE;
      sclMeta <= 1'b1;
      sclSync <= 1'b1;
      sdaMeta <= 1'b1;
      sdaSync <= 1'b1;
    end else begin
      pinsMeta <= pinsNow;
      pinsSync <= pinsMeta;
      sclMeta <= sclLink;
      sclSync <= sclMeta;
      sdaMeta <= serialDataIn;
      sdaSync <= sdaMeta;
    end
  end

  // Mode and access decode
  always_comb begin
    // Both strobes low with the first style is a strap, not an access
    i2cMode = pinsSync.busStyleSelect & ~pinsSync.readStrobeN & ~pinsSync.writeStrobeN;
    rdAct = 1'b0;
    wrAct = 1'b0;
    if (!pinsSync.chipSelectN && !i2cMode) begin
      if (pinsSync.busStyleSelect) begin
        rdAct = ~pinsSync.readStrobeN;
        wrAct = ~pinsSync.writeStrobeN;
      end else begin
        // Read pin is a direction level, write pin the data strobe
        rdAct = pinsSync.readStrobeN & ~pinsSync.writeStrobeN;
        wrAct = ~pinsSync.readStrobeN & ~pinsSync.writeStrobeN;
      end
    end
    wrEdge = wrAct & ~wrPrev;
    reqNew = reqSync ^ reqSeen;
  end

  // Write access edge tracking: one store per strobe
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      wrPrev <= 1'b0;
    end else begin
      wrPrev <= wrAct;
    end
  end

  // Control bytes; a parallel write edge wins over a serial write request in the same
  // cycle, and that serial request is then consumed without being stored
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      controlBytes <= {REG_COUNT{CTRL_RST}};
    end else if (wrEdge) begin
      controlBytes[pinsSync.sel] <= pinsSync.data;
    end else if (reqNew && reqReg.wr) begin
      controlBytes[reqReg.sel] <= reqReg.data;
    end
  end

  // Parallel read data drive; bus floats in serial mode and when idle
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      hostDataOut <= '0;
      hostDataOeN <= 1'b1;
    end else if (rdAct) begin
      hostDataOut <= statusBytes[pinsSync.sel];
      hostDataOeN <= 1'b0;
    end else begin
      hostDataOeN <= 1'b1;
    end
  end

  // Acknowledge: driven low once read data stands or a write has been taken
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      transferAcknowledge <= 1'b0;
      transferAcknowledgeOeN <= 1'b1;
    end else begin
      transferAcknowledge <= 1'b0;
      transferAcknowledgeOeN <= ~((rdAct & ~hostDataOeN) | (wrAct & wrPrev));
    end
  end

  // Own serial address, recomputed every cycle from the straps
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      slaveAddrReg <= '0;
    end else if (ADDR_FROM_SELECTS) begin
      slaveAddrReg <= {1'b0, {2{pinsSync.addrSelect[2]}}, {2{pinsSync.addrSelect[1]}},
                       {2{pinsSync.addrSelect[0]}}};
    end else begin
      slaveAddrReg <= pinsSync.data[SLAVE_W-1:0];
    end
  end

  // Bypass pass-through; a synchronised copy trades two to three mclk cycles of delay for safety
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      bypassOeN <= 1'b1;
      bypassSerialClockOut <= 1'b1;
      bypassSerialDataOut <= 1'b1;
    end else begin
      bypassOeN <= ~controlBytes[BYPASS_REG][BYPASS_BIT];
      bypassSerialClockOut <= sclSync;
      bypassSerialDataOut <= sdaSync;
    end
  end

  // Serve requests from the serial domain: optional write, then fetch and answer
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      reqMeta <= 1'b0;
      reqSync <= 1'b0;
      reqSeen <= 1'b0;
      rdDataReg <= '0;
      ackTog <= 1'b0;
    end else begin
      reqMeta <= reqTog;
      reqSync <= reqMeta;
      if (reqNew) begin
        reqSeen <= reqSync;
        rdDataReg <= statusBytes[reqReg.sel];
        ackTog <= ~ackTog;
      end
    end
  end

  // Start detection: data falls while the serial clock is high
  always_ff @(negedge serialDataIn or posedge rst) begin
    if (rst) begin
      startTog <= 1'b0;
    end else if (sclLink) begin
      startTog <= ~startTog;
    end
  end

  always_comb begin
    startPend = startTog ^ startAck;
    addrMatch = (shiftIn[7:1] == addrSync);
  end

  // Serial protocol engine, sampling on the rising serial clock; slave only
  always_ff @(posedge sclLink or posedge rst) begin
    if (rst) begin
      startAck <= 1'b0;
      state <= I2C_IDLE;
      bitCnt <= BIT_FIRST;
      shiftIn <= '0;
      ptr <= '0;
      reqReg <= '0;
      reqTog <= 1'b0;
    end else if (startPend) begin
      // Start or repeated start always restarts address reception
      startAck <= startTog;
      state <= I2C_DEVADDR;
      bitCnt <= BIT_AFTER_START;
      shiftIn <= {7'h00, serialDataIn};
    end else if (state != I2C_IDLE) begin
      if (bitCnt != ACK_SLOT) begin
        bitCnt <= bitCnt + 4'h1;
        if (state != I2C_RDDATA) begin
          shiftIn <= {shiftIn[6:0], serialDataIn};
        end else if (bitCnt == BIT_FIRST) begin
          // Byte now leaving came from ptr; fetch the next one ahead of time
          ptr <= ptr + 8'h01;
          reqReg <= '{wr: 1'b0, sel: ptr[SEL_W-1:0] + 5'h01, data: 8'h00};
          reqTog <= ~reqTog;
        end
      end else begin
        bitCnt <= BIT_FIRST;
        case (state)
          I2C_DEVADDR: begin
            if (!addrMatch) begin
              state <= I2C_IDLE;
            end else if (shiftIn[0]) begin
              state <= I2C_RDDATA;
            end else begin
              state <= I2C_WORDADDR;
            end
          end
          I2C_WORDADDR: begin
            ptr <= shiftIn;
            reqReg <= '{wr: 1'b0, sel: shiftIn[SEL_W-1:0], data: 8'h00};
            reqTog <= ~reqTog;
            state <= I2C_WRDATA;
          end
          I2C_WRDATA: begin
            reqReg <= '{wr: 1'b1, sel: ptr[SEL_W-1:0], data: shiftIn};
            reqTog <= ~reqTog;
            ptr <= ptr + 8'h01;
          end
          I2C_RDDATA: begin
            if (serialDataIn) begin
              state <= I2C_IDLE;
            end
          end
          default: begin
            state <= I2C_IDLE;
          end
        endcase
      end
    end
  end

  // Bring back answers and the own address on the serial clock
  always_ff @(posedge sclLink or posedge rst) begin
    if (rst) begin
      ackMeta <= 1'b0;
      ackSync <= 1'b0;
      ackSeen <= 1'b0;
      rxData <= '0;
      addrMeta <= '0;
      addrSync <= '0;
    end else begin
      ackMeta <= ackTog;
      ackSync <= ackMeta;
      ackSeen <= ackSync;
      addrMeta <= slaveAddrReg;
      addrSync <= addrMeta;
      if (ackSync ^ ackSeen) begin
        // mclk holds rdDataReg steady until the next request
        rxData <= rdDataReg;
      end
    end
  end

  // Data line drive, changed only while the serial clock is low
  always_ff @(negedge sclLink or posedge rst) begin
    if (rst) begin
      txByte <= '0;
      serialDataOeN <= 1'b1;
    end else if (startPend) begin
      serialDataOeN <= 1'b1;
    end else if (bitCnt == ACK_SLOT && (state == I2C_WORDADDR || state == I2C_WRDATA ||
                 (state == I2C_DEVADDR && addrMatch))) begin
      serialDataOeN <= 1'b0;
    end else if (state == I2C_RDDATA && bitCnt == BIT_FIRST) begin
      txByte <= {rxData[6:0], 1'b0};
      serialDataOeN <= rxData[7];
    end else if (state == I2C_RDDATA && bitCnt != ACK_SLOT) begin
      txByte <= {txByte[6:0], 1'b0};
      serialDataOeN <= txByte[7];
    end else begin
      // Ack slot of a read and idle: line left to the master
      serialDataOeN <= 1'b1;
    end
  end

  // Open-drain data only ever pulls low
  always_ff @(negedge sclLink or posedge rst) begin
    if (rst) begin
      serialDataOut <= 1'b0;
    end else begin
      serialDataOut <= 1'b0;
    end
  end

endmodule : host_monitor_control_port

// File: rtl/host_port_pkg.sv
/*
  Shared constants and types for the host monitor and control port.
  Assumes a register space of 32 byte-wide locations.
*/
package host_port_pkg;
  localparam int DATA_W = 8;                    // Host data bus width
  localparam int SEL_W = 5;                     // Host register select width
  localparam int REG_COUNT = 32;                // Locations reached by the select bus
  localparam int SLAVE_W = 7;                   // Serial slave address width
  localparam logic [4:0] BYPASS_REG = 5'h10;    // Control byte holding the bypass enable
  localparam int BYPASS_BIT = 4;                // Bypass enable position in that byte
  localparam logic [7:0] CTRL_RST = 8'h00;      // Control byte value after reset
  localparam logic [3:0] ACK_SLOT = 4'h8;       // Ninth clock of a serial byte
  localparam logic [3:0] BIT_FIRST = 4'h0;      // Count at the first bit of a byte
  localparam logic [3:0] BIT_AFTER_START = 4'h1;// Count once the first bit is taken

  typedef logic [DATA_W-1:0] byte_t;
  typedef logic [SEL_W-1:0] regSel_t;

  // Serial engine phases
  typedef enum logic [2:0] {
    I2C_IDLE,
    I2C_DEVADDR,
    I2C_WORDADDR,
    I2C_WRDATA,
    I2C_RDDATA
  } i2cState_t;

  // Register request handed from the serial domain to the system clock domain
  typedef struct packed {
    logic wr;
    regSel_t sel;
    byte_t data;
  } regReq_t;

  // Host pins as seen after synchronisation
  typedef struct packed {
    logic chipSelectN;
    logic readStrobeN;
    logic writeStrobeN;
    logic busStyleSelect;
    logic [2:0] addrSelect;
    regSel_t sel;
    byte_t data;
  } hostPins_t;

  // Idle pin levels loaded into the synchronisers, so reset shows no access
  localparam hostPins_t PINS_IDLE = '{chipSelectN: 1'b1, readStrobeN: 1'b1,
    writeStrobeN: 1'b1, busStyleSelect: 1'b1, default: '0};
endpackage : host_port_pkg

// File: verification/host_master_model.sv
/*
  Two-wire bus master model: makes the serial clock and drives data.
  Assumes the bench resolves the open-drain data wire with a pull-up.
*/
`timescale 1ns/10ps
module host_master_model (
  output logic scl,
  output logic sda,
  input wire logic sdaLine
);
  int lowExtra = 0; // Stretches clock low time to act as a slow master
  // Clock stands high between frames, data released
  initial begin
    scl = 1'b1;
    sda = 1'b1;
  end
  // Start or repeated start: data falls while clock is high
  task start;
    sda = 1'b1;
    #16 scl = 1'b1;
    #16 sda = 1'b0;
    #16 scl = 1'b0;
    #16;
  endtask : start
  // Data changes only while clock is low
  task bitOut(input logic b);
    sda = b;
    #(16 + lowExtra) scl = 1'b1;
    #32 scl = 1'b0;
    #16;
  endtask : bitOut
  // Release data and sample mid-high; released line reads the pull-up
  task bitIn(output logic b);
    sda = 1'b1;
    #(16 + lowExtra) scl = 1'b1;
    #16 b = sdaLine;
    #16 scl = 1'b0;
    #16;
  endtask : bitIn
  // Byte out MSB first, then the slave's acknowledge slot
  task sendByte(input logic [7:0] d, output logic acked);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      bitOut(d[i]);
    end
    bitIn(r);
    acked = !r;
  endtask : sendByte
  // Byte in, then our acknowledge (low) or no-ack (high)
  task recvByte(input logic ack, output logic [7:0] d);
    for (int i = 7; i >= 0; i--) begin
      bitIn(d[i]);
    end
    bitOut(!ack);
  endtask : recvByte
  // Stop: data rises while clock is high
  task stop;
    sda = 1'b0;
    #16 scl = 1'b1;
    #16 sda = 1'b1;
    #16;
  endtask : stop
endmodule : host_master_model

// File: verification/host_monitor_control_port_tb.sv
/*
  Testbench for the host port: parallel accesses in both styles and
  serial transfers through the master model. Assumes straps give 7'h33.
*/
`timescale 1ns/10ps
module host_monitor_control_port_tb;
  import host_port_pkg::*;
  logic mclk = 1'b0;
  logic rst = 1'b0;
  logic sclLink, mSda, serialDataIn, a;
  logic chipSelectN = 1'b1, readStrobeN = 1'b1, writeStrobeN = 1'b1, busStyleSelect = 1'b1;
  byte_t tbData = 8'h00, rd;
  byte_t hostDataIn;
  regSel_t hostRegisterSelect = 5'h00;
  byte_t [REG_COUNT-1:0] statusBytes, controlBytes;
  logic [DATA_W-1:0] hostDataOut;
  logic hostDataOeN, transferAcknowledge, transferAcknowledgeOeN, serialDataOut, serialDataOeN;
  logic bypassSerialClockOut, bypassSerialDataOut, bypassOeN;
  int n_fail = 0;
  int n_tests = 0;
  // Clock and resolved wires; the data bus shows the device when it drives
  always #5 mclk = ~mclk;
  assign hostDataIn = hostDataOeN ? tbData : hostDataOut;
  assign serialDataIn = mSda & (serialDataOeN | serialDataOut);
  // Fixed status pattern, distinct per location
  function automatic byte_t stat(input int i);
    return 8'h5a ^ byte_t'(i * 7);
  endfunction : stat
  always_comb begin
    for (int i = 0; i < REG_COUNT; i++) begin
      statusBytes[i] = stat(i);
    end
  end
  host_monitor_control_port uut (.mclk(mclk), .rst(rst), .sclLink(sclLink),
    .serialDataIn(serialDataIn), .hostDataIn(hostDataIn), .hostRegisterSelect(hostRegisterSelect),
    .chipSelectN(chipSelectN), .readStrobeN(readStrobeN), .writeStrobeN(writeStrobeN),
    .busStyleSelect(busStyleSelect), .slaveAddrSelect0(1'b1), .slaveAddrSelect1(1'b0),
    .slaveAddrSelect2(1'b1), .statusBytes(statusBytes), .hostDataOut(hostDataOut),
    .hostDataOeN(hostDataOeN), .transferAcknowledge(transferAcknowledge),
    .transferAcknowledgeOeN(transferAcknowledgeOeN), .serialDataOut(serialDataOut),
    .serialDataOeN(serialDataOeN), .bypassSerialClockOut(bypassSerialClockOut),
    .bypassSerialDataOut(bypassSerialDataOut), .bypassOeN(bypassOeN),
    .controlBytes(controlBytes));
  host_master_model m (.scl(sclLink), .sda(mSda), .sdaLine(serialDataIn));
  task end_sim;
    $display("Comparisons %0d, mismatches %0d", n_tests, n_fail);
    if (n_fail == 0 && n_tests > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : end_sim
  task chk(input string what, input logic [7:0] exp, input logic [7:0] got);
    n_tests++;
    if (got !== exp) begin
      n_fail++;
      $display("unexpected %s: expected %h, seen %h", what, exp, got);
    end
  endtask : chk
  // Pins change a fixed 1 ns after the rising edge
  task setPins(input logic cs, re, we, st, input regSel_t s, input byte_t d);
    @(posedge mclk) #1;
    chipSelectN = cs;
    readStrobeN = re;
    writeStrobeN = we;
    busStyleSelect = st;
    hostRegisterSelect = s;
    tbData = d;
  endtask : setPins
  // Bounded wait on the ack enable or the bus enable reaching a level
  task waitLvl(input logic ack, input logic lvl);
    for (int i = 0; i < 40; i++) begin
      @(posedge mclk) #1;
      if ((ack ? transferAcknowledgeOeN : hostDataOeN) === lvl) return;
    end
    n_fail++;
    $display("unexpected timeout: expected %b, seen none", lvl);
    end_sim();
  endtask : waitLvl
  // Write: second style uses read pin low as the write level
  task parWrite(input logic st, input regSel_t s, input byte_t d);
    setPins(1'b0, st, 1'b0, st, s, d);
    waitLvl(1'b1, 1'b0);
    chk("control byte", d, controlBytes[s]);
    chk("ack level", 8'h00, {7'h00, transferAcknowledge});
    setPins(1'b1, 1'b1, 1'b1, st, s, d);
    waitLvl(1'b1, 1'b1);
  endtask : parWrite
  task parRead(input logic st, input regSel_t s);
    setPins(1'b0, !st, st, st, s, 8'h00);
    waitLvl(1'b0, 1'b0);
    chk("read data", stat(s), hostDataOut);
    waitLvl(1'b1, 1'b0);
    setPins(1'b1, 1'b1, 1'b1, st, s, 8'h00);
    waitLvl(1'b0, 1'b1);
    waitLvl(1'b1, 1'b1);
  endtask : parRead
  // Both styles, boundary locations, back-to-back accesses
  task scnParallel;
    for (int st = 1; st >= 0; st--) begin
      parWrite(st[0], 5'h03 + 5'(st), 8'hc3 ^ 8'(st));
      parWrite(st[0], 5'h1f, 8'h81 + 8'(st));
      parRead(st[0], 5'h1f);
      parRead(st[0], 5'h00);
    end
  endtask : scnParallel
  // Write pattern with chip select high, then the serial strap
  task scnRefused;
    setPins(1'b1, 1'b1, 1'b0, 1'b1, 5'h07, 8'hff);
    repeat (8) @(posedge mclk);
    chk("deselected write", 8'h00, controlBytes[7]);
    chk("ack enable", 8'h01, {7'h00, transferAcknowledgeOeN});
    setPins(1'b0, 1'b0, 1'b0, 1'b1, 5'h08, 8'hee);
    repeat (8) @(posedge mclk);
    chk("strap write", 8'h00, controlBytes[8]);
    chk("strap bus enable", 8'h01, {7'h00, hostDataOeN});
    chk("bypass enable", 8'h01, {7'h00, bypassOeN});
  endtask : scnRefused
  // Serial write of bypass control and the next location
  task scnSerialWrite;
    m.start();
    m.sendByte(8'h66, a);
    chk("address ack", 8'h01, {7'h00, a});
    m.sendByte(8'h10, a);
    chk("word ack", 8'h01, {7'h00, a});
    m.sendByte(8'h10, a);
    chk("data ack", 8'h01, {7'h00, a});
    m.sendByte(8'h5a, a);
    m.stop();
    repeat (6) @(posedge mclk);
    chk("serial byte", 8'h10, controlBytes[16]);
    chk("next byte", 8'h5a, controlBytes[17]);
    chk("bypass enable", 8'h00, {7'h00, bypassOeN});
    chk("bypass clock", 8'h01, {7'h00, bypassSerialClockOut});
  endtask : scnSerialWrite
  // Read across the last two locations by a slow master, no-ack ends it
  task scnSerialRead;
    m.lowExtra = 200;
    m.start();
    m.sendByte(8'h66, a);
    m.sendByte(8'h1e, a);
    m.start();
    m.sendByte(8'h67, a);
    chk("read address ack", 8'h01, {7'h00, a});
    m.recvByte(1'b1, rd);
    chk("first read", stat(30), rd);
    m.recvByte(1'b0, rd);
    chk("second read", stat(31), rd);
    chk("line released", 8'h01, {7'h00, serialDataOeN});
    m.stop();
    m.lowExtra = 0;
  endtask : scnSerialRead
  // Another address: no ack, nothing stored
  task scnWrongAddr;
    m.start();
    m.sendByte(8'h7e, a);
    chk("foreign ack", 8'h00, {7'h00, a});
    m.sendByte(8'h00, a);
    m.sendByte(8'hff, a);
    m.stop();
    repeat (6) @(posedge mclk);
    chk("foreign write", 8'h00, controlBytes[0]);
  endtask : scnWrongAddr
  initial begin
    // Raised after time zero so the reset edge reaches the serial clock domain too
    #1 rst = 1'b1;
    repeat (12) @(posedge mclk);
    #1 rst = 1'b0;
    repeat (3) @(posedge mclk);
    scnParallel();
    scnRefused();
    scnSerialWrite();
    scnSerialRead();
    scnWrongAddr();
    end_sim();
  end
endmodule : host_monitor_control_port_tb

// File: verification/host_port_props.sv
/*
  Checker for the host port: parallel strobe timing, acknowledge, bypass gating.
  Assumes it is bound to the top module and sees only its ports.
*/
`timescale 1ns/10ps
module host_port_props
  import host_port_pkg::*;
(
  input wire logic mclk,
  input wire logic rst,
  input wire logic sclLink,
  input wire host_port_pkg::byte_t hostDataIn,
  input wire host_port_pkg::regSel_t hostRegisterSelect,
  input wire logic chipSelectN,
  input wire logic readStrobeN,
  input wire logic writeStrobeN,
  input wire logic busStyleSelect,
  input wire host_port_pkg::byte_t [host_port_pkg::REG_COUNT-1:0] statusBytes,
  input wire logic [host_port_pkg::DATA_W-1:0] hostDataOut,
  input wire logic hostDataOeN,
  input wire logic transferAcknowledge,
  input wire logic transferAcknowledgeOeN,
  input wire logic bypassSerialClockOut,
  input wire logic bypassOeN,
  input wire host_port_pkg::byte_t [host_port_pkg::REG_COUNT-1:0] controlBytes
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);
  // Pin patterns of each access kind; five samples cover the two-flop sync
  sequence rdFirst;
    busStyleSelect && !chipSelectN && !readStrobeN && writeStrobeN;
  endsequence
  sequence rdSecond;
    !busStyleSelect && !chipSelectN && readStrobeN && !writeStrobeN;
  endsequence
  sequence wrFirst;
    busStyleSelect && !chipSelectN && readStrobeN && !writeStrobeN;
  endsequence
  sequence wrSecond;
    !busStyleSelect && !chipSelectN && !readStrobeN && !writeStrobeN;
  endsequence
  a_cs_idle: assert property (
    chipSelectN [*5] |-> hostDataOeN && transferAcknowledgeOeN)
    else $error("bus or ack driven while deselected");
  a_read_first: assert property (
    rdFirst [*5] |-> !hostDataOeN && hostDataOut == statusBytes[hostRegisterSelect])
    else $error("first style read data wrong");
  a_read_second: assert property (
    rdSecond [*5] |-> !hostDataOeN && hostDataOut == statusBytes[hostRegisterSelect])
    else $error("second style read data wrong");
  a_write_first: assert property (
    wrFirst [*5] |-> controlBytes[hostRegisterSelect] == hostDataIn)
    else $error("first style write not stored");
  a_write_second: assert property (
    wrSecond [*5] |-> controlBytes[hostRegisterSelect] == hostDataIn)
    else $error("second style write not stored");
  a_serial_quiet: assert property (
    (busStyleSelect && !readStrobeN && !writeStrobeN) [*5] |-> hostDataOeN)
    else $error("serial strap answered as parallel read");
  a_ack_cause: assert property (
    $fell(transferAcknowledgeOeN) |-> !$past(chipSelectN, 3) && !transferAcknowledge)
    else $error("ack without a selected access");
  a_bypass_off: assert property (
    (!controlBytes[BYPASS_REG][BYPASS_BIT]) [*4] |-> bypassOeN)
    else $error("bypass enabled while its bit is clear");
  a_bypass_on: assert property (
    (controlBytes[BYPASS_REG][BYPASS_BIT] && $stable(sclLink)) [*4]
      |-> !bypassOeN && bypassSerialClockOut == sclLink)
    else $error("bypass clock not passed through");
endmodule : host_port_props

bind host_monitor_control_port host_port_props chk (.mclk, .rst, .sclLink, .hostDataIn,
  .hostRegisterSelect, .chipSelectN, .readStrobeN, .writeStrobeN, .busStyleSelect,
  .statusBytes, .hostDataOut, .hostDataOeN, .transferAcknowledge, .transferAcknowledgeOeN,
  .bypassSerialClockOut, .bypassOeN, .controlBytes);
